// *** pot_bus_master.sv ***
// Two-wire bus master model for the potentiometer slave.
`timescale 1ns/100ps
`default_nettype none
module pot_bus_master (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output var logic  scl_out,
	output var logic  sda_out
);
	// Idle lines stand released high; clock stands still between frames
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Data moves only mid clock-low; 16 clocks give a 64 ns bit
	task automatic send_bit(input logic b, output logic seen);
		wait_clk(4);
		sda_out = b;
		wait_clk(4);
		scl_out = 1'b1;
		wait_clk(4);
		seen = sda_in;
		wait_clk(4);
		scl_out = 1'b0;
	endtask
	task automatic start();
		wait_clk(4);
		sda_out = 1'b1;
		wait_clk(4);
		scl_out = 1'b1;
		wait_clk(8);
		sda_out = 1'b0;
		wait_clk(8);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		wait_clk(4);
		sda_out = 1'b0;
		wait_clk(4);
		scl_out = 1'b1;
		wait_clk(8);
		sda_out = 1'b1;
		wait_clk(8);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(b[i], s);
		send_bit(1'b1, s);
		ack = !s;
	endtask
	task automatic read_byte(output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(1'b1, s);
			b[i] = s;
		end
		send_bit(1'b1, s);
	endtask
endmodule // pot_bus_master
`default_nettype wire

// *** pot_slave.v ***
// Two-wire slave front end and wiper logic of a digital potentiometer.
`timescale 1ns/100ps
`default_nettype none
`include "pot_slave_map.vh"

module pot_slave #(
	parameter [3:0] TYPE_CODE    = 4'hA, // Arbitrary neutral type code
	parameter       DEVADDR_BIT1 = 1'b0,
	parameter       WRITE_CYCLES = `NV_WRITE_US * `CLK_MHZ,
	parameter       CNT_W        = 22
) (
	input  wire        sys_clk_in,
	input  wire        rst_n_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_out,
	input  wire        addr_strap_bit_low_in,
	input  wire        addr_strap_bit_mid_in,
	input  wire        addr_strap_bit_high_in,
	input  wire        write_protect_n_in,
	output wire [63:0] tap_select_out,
	output wire [5:0]  wiper_position_out,
	output wire        write_busy_out
);

	// ************************************************************
	// States
	// ************************************************************
	localparam [3:0] ST_IDLE     = 4'h0;
	localparam [3:0] ST_ADDR     = 4'h1;
	localparam [3:0] ST_ACK_ADDR = 4'h2;
	localparam [3:0] ST_CMD      = 4'h3;
	localparam [3:0] ST_ACK_CMD  = 4'h4;
	localparam [3:0] ST_DATA     = 4'h5;
	localparam [3:0] ST_ACK_DATA = 4'h6;
	localparam [3:0] ST_READ     = 4'h7;
	localparam [3:0] ST_MACK     = 4'h8;
	localparam [3:0] ST_INCDEC   = 4'h9;
	localparam [3:0] ST_IGNORE   = 4'hA;

	function [63:0] one_hot;
		input [5:0] pos;
		begin
			one_hot = 64'h0000_0000_0000_0001 << pos;
		end
	endfunction

	// ************************************************************
	// Pin synchronisers and bus events
	// ************************************************************
	reg [1:0] scl_sync_reg;
	reg [1:0] sda_sync_reg;
	reg [1:0] wp_sync_reg;
	reg [2:0] strap_meta_reg;
	reg [2:0] strap_reg;
	reg       scl_prev_reg;
	reg       sda_prev_reg;

	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_reg   <= 2'h3;
			sda_sync_reg   <= 2'h3;
			wp_sync_reg    <= 2'h3;
			strap_meta_reg <= 3'h0;
			strap_reg      <= 3'h0;
			scl_prev_reg   <= 1'b1;
			sda_prev_reg   <= 1'b1;
		end else begin
			scl_sync_reg   <= {scl_sync_reg[0], scl_in};
			sda_sync_reg   <= {sda_sync_reg[0], sda_in};
			wp_sync_reg    <= {wp_sync_reg[0], write_protect_n_in};
			strap_meta_reg <= {addr_strap_bit_high_in, addr_strap_bit_mid_in,
				addr_strap_bit_low_in};
			strap_reg      <= strap_meta_reg;
			scl_prev_reg   <= scl_sync_reg[1];
			sda_prev_reg   <= sda_sync_reg[1];
		end
	end

	wire scl_s  = scl_sync_reg[1];
	wire sda_s  = sda_sync_reg[1];
	wire wp_n_s = wp_sync_reg[1];
	wire scl_rise = scl_s & ~scl_prev_reg;
	wire scl_fall = ~scl_s & scl_prev_reg;
	// Data moving under a high clock is framing, never a bit
	wire start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // see [RL1] [RL2]
	wire stop_ev  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // see [RL1] [RL3]

	// ************************************************************
	// Protocol engine
	// ************************************************************
	reg [3:0]       state_reg;
	reg [7:0]       shift_reg;
	reg [2:0]       bit_cnt_reg;
	reg             ack_en_reg;
	reg             ack_phase_reg;
	reg             drive_reg;
	reg [7:0]       tx_reg;
	reg [3:0]       opc_reg;
	reg [1:0]       sel_reg;
	reg [5:0]       wiper_reg;
	reg [5:0]       store_reg [0:3];
	reg             nv_pend_reg;
	reg [1:0]       nv_sel_reg;
	reg [5:0]       nv_val_reg;
	reg             busy_reg;
	reg [CNT_W-1:0] busy_cnt_reg;
	reg [63:0]      tap_reg;

	wire [7:0] byte_in = {shift_reg[6:0], sda_s};
	wire       byte_done = scl_rise & (bit_cnt_reg == `BYTE_LAST_BIT);
	wire [3:0] dev_addr = {strap_reg[2], strap_reg[1], DEVADDR_BIT1,
		strap_reg[0]}; // see [RL6]
	wire       addr_hit = (byte_in[`TYPE_HI:`TYPE_LO] == TYPE_CODE) && // see [RL7]
		(byte_in[`DEVADDR_BIT3:`DEVADDR_BIT0] == dev_addr); // see [RL8]
	wire [3:0] opc_in = byte_in[`OPC_HI:`OPC_LO];
	wire       opc_ok = (opc_in == `OPC_INCDEC) ?
		(byte_in[`INCDEC_PAD] == 1'b0) :
		((byte_in[`PAD_HI:`PAD_LO] == 2'h0) &&
		(opc_in >= `OPC_RD_WIPER) && (opc_in <= `OPC_SAVE_WIPER)); // see [RL16]
	wire       opc_data = (opc_in == `OPC_WR_WIPER) ||
		(opc_in == `OPC_WR_STORE);
	wire [5:0] rd_val = (opc_reg == `OPC_RD_WIPER) ? wiper_reg :
		store_reg[sel_reg];
	wire       busy_done = busy_reg &&
		(busy_cnt_reg == WRITE_CYCLES[CNT_W-1:0] - 1'b1);

	integer i;

	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= 8'h00;
			bit_cnt_reg   <= 3'h0;
			ack_en_reg    <= 1'b0;
			ack_phase_reg <= 1'b0;
			drive_reg     <= 1'b0;
			tx_reg        <= 8'h00;
			opc_reg       <= 4'h0;
			sel_reg       <= 2'h0;
			wiper_reg     <= `STORE_RESET; // Power-up recall of store zero
			for (i = 0; i < 4; i = i + 1)
				store_reg[i] <= `STORE_RESET;
			nv_pend_reg   <= 1'b0;
			nv_sel_reg    <= 2'h0;
			nv_val_reg    <= 6'h00;
			busy_reg      <= 1'b0;
			busy_cnt_reg  <= {CNT_W{1'b0}};
			tap_reg       <= 64'h0000_0000_0000_0001;
		end else begin
			tap_reg <= one_hot(wiper_reg); // see [RL11]
			// Internal write cycle; the value lands when it ends
			if (busy_reg) begin
				busy_cnt_reg <= busy_cnt_reg + 1'b1;
				if (busy_done) begin // see [RL13] [RL17]
					busy_reg <= 1'b0;
					store_reg[nv_sel_reg] <= nv_val_reg;
				end
			end
			if (start_ev) begin
				// Also serves acknowledge polling during a write
				state_reg   <= ST_ADDR; // see [RL18] [RL15]
				bit_cnt_reg <= 3'h0;
				drive_reg   <= 1'b0;
				nv_pend_reg <= 1'b0;
			end else if (stop_ev) begin
				state_reg <= ST_IDLE; // see [RL18]
				drive_reg <= 1'b0;
				nv_pend_reg <= 1'b0;
				if (nv_pend_reg && wp_n_s && !busy_reg) begin // see [RL10] [RL13]
					busy_reg     <= 1'b1;
					busy_cnt_reg <= {CNT_W{1'b0}};
				end
			end else begin
				case (state_reg)
				ST_ADDR, ST_CMD, ST_DATA: begin
					if (scl_rise) begin // see [RL9]
						shift_reg   <= byte_in;
						bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end
					if (byte_done) begin
						ack_phase_reg <= 1'b0;
						if (state_reg == ST_ADDR) begin
							ack_en_reg <= addr_hit & ~busy_reg; // see [RL14]
							state_reg  <= ST_ACK_ADDR;
						end else if (state_reg == ST_CMD) begin
							ack_en_reg <= opc_ok;
							state_reg  <= ST_ACK_CMD;
							opc_reg    <= opc_in;
							sel_reg    <= byte_in[`SEL_HI:`SEL_LO];
						end else begin
							ack_en_reg <= 1'b1;
							state_reg  <= ST_ACK_DATA;
						end
					end
				end
				ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_DATA: begin
					if (scl_fall && !ack_phase_reg) begin
						drive_reg     <= ack_en_reg; // see [RL4] [RL5]
						ack_phase_reg <= 1'b1;
					end else if (scl_fall) begin
						drive_reg   <= 1'b0;
						bit_cnt_reg <= 3'h0;
						if (!ack_en_reg)
							state_reg <= ST_IGNORE; // see [RL8]
						else if (state_reg == ST_ACK_ADDR)
							state_reg <= ST_CMD;
						else if (state_reg == ST_ACK_DATA) begin
							state_reg <= ST_IGNORE;
							if (opc_reg == `OPC_WR_WIPER)
								wiper_reg <= shift_reg[5:0]; // see [RL12]
							else begin
								nv_pend_reg <= 1'b1;
								nv_sel_reg  <= sel_reg;
								nv_val_reg  <= shift_reg[5:0];
							end
						end else begin
							case (opc_reg)
							`OPC_RD_WIPER, `OPC_RD_STORE: begin
								// Transmitter drives the first bit now
								state_reg <= ST_READ; // see [RL12]
								drive_reg <= 1'b1;
								tx_reg    <= {1'b0, rd_val, 1'b0};
							end
							`OPC_WR_WIPER, `OPC_WR_STORE:
								state_reg <= ST_DATA;
							`OPC_LOAD_WIPER: begin
								wiper_reg <= store_reg[sel_reg]; // see [RL12]
								state_reg <= ST_IGNORE;
							end
							`OPC_SAVE_WIPER: begin
								nv_pend_reg <= 1'b1;
								nv_sel_reg  <= sel_reg;
								nv_val_reg  <= wiper_reg;
								state_reg   <= ST_IGNORE;
							end
							`OPC_INCDEC:
								state_reg <= ST_INCDEC;
							default:
								state_reg <= ST_IGNORE;
							endcase
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						drive_reg <= ~tx_reg[7];
						tx_reg    <= {tx_reg[6:0], 1'b0};
					end
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 1'b1;
						if (bit_cnt_reg == `BYTE_LAST_BIT)
							state_reg <= ST_MACK;
					end
				end
				ST_MACK: begin
					// Release for the master's ninth-clock answer
					if (scl_fall) begin
						drive_reg <= 1'b0; // see [RL4]
						state_reg <= ST_IGNORE;
					end
				end
				ST_INCDEC: begin
					// Steps saturate at the array ends rather than wrap
					if (scl_rise) begin
						if (sda_s && wiper_reg != `WIPER_MAX)
							wiper_reg <= wiper_reg + 1'b1;
						else if (!sda_s && wiper_reg != `WIPER_MIN)
							wiper_reg <= wiper_reg - 1'b1;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					drive_reg <= 1'b0; // see [RL2]
				end
				default: begin
					state_reg <= ST_IDLE;
					drive_reg <= 1'b0;
				end
				endcase
			end
		end
	end

	assign sda_out            = 1'b0;
	assign sda_oe_out         = drive_reg;
	assign tap_select_out     = tap_reg;
	assign wiper_position_out = wiper_reg;
	assign write_busy_out     = busy_reg;

endmodule // pot_slave

`default_nettype wire

// *** pot_slave_map.vh ***
// Constants of the two-wire potentiometer slave front end.
// What this block does
// [RL1] Data changes only while clock low
// [RL2] Ignore bus until a start condition
// [RL3] Master ends each transfer with stop
// [RL4] Receiver pulls data low on ninth clock
// [RL5] Acknowledge address, command and data bytes
// [RL6] Three straps give address bits 3, 2 and 0
// [RL7] Upper address nibble must equal type code
// [RL8] All four device-address bits must match
// [RL9] Device is always a clocked slave
// [RL10] Write-protect low blocks nonvolatile writes
// [RL11] Wiper value enables exactly one tap
// [RL12] Wiper: direct write, stored load, read
// [RL13] Stop starts write cycle, inputs disabled
// [RL14] No address acknowledge while write runs
// [RL15] Master polls with start plus address
// [RL16] Command: opcode, register select, zeros
// [RL17] Nonvolatile change completes within 10ms
// [RL18] Start restarts, stop returns to idle
`ifndef POT_SLAVE_MAP_VH
`define POT_SLAVE_MAP_VH

// ************************************************************
// Byte layout
// ************************************************************
`define BYTE_LAST_BIT   3'h7
`define TYPE_HI         7
`define TYPE_LO         4
`define DEVADDR_BIT3    3
`define DEVADDR_BIT2    2
`define DEVADDR_BIT1    1
`define DEVADDR_BIT0    0
`define OPC_HI          7
`define OPC_LO          4
`define SEL_HI          3
`define SEL_LO          2
`define PAD_HI          1
`define PAD_LO          0
`define INCDEC_PAD      1

// ************************************************************
// Opcodes
// ************************************************************
`define OPC_RD_WIPER    4'h9
`define OPC_WR_WIPER    4'hA
`define OPC_RD_STORE    4'hB
`define OPC_WR_STORE    4'hC
`define OPC_LOAD_WIPER  4'hD
`define OPC_SAVE_WIPER  4'hE
`define OPC_INCDEC      4'h2

// ************************************************************
// Values and timing
// ************************************************************
`define WIPER_MAX       6'h3F
`define WIPER_MIN       6'h00
`define STORE_RESET     6'h00
`define CLK_MHZ         250
`define NV_WRITE_US     5000
`define NV_LIMIT_US     10000

`endif

// *** pot_slave_properties.sv ***
// Port checker of the potentiometer slave.
`timescale 1ns/100ps
`default_nettype none
module pot_slave_properties #(
	parameter WRITE_CYCLES = 400
) (
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_out,
	input wire logic        addr_strap_bit_low_in,
	input wire logic        addr_strap_bit_mid_in,
	input wire logic        addr_strap_bit_high_in,
	input wire logic        write_protect_n_in,
	input wire logic [63:0] tap_select_out,
	input wire logic [5:0]  wiper_position_out,
	input wire logic        write_busy_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [3:0]  rise_reg;
	logic [31:0] busy_reg;
	sequence start_seq; scl_in && $fell(sda_in); endsequence
	sequence ack_seq; $rose(sda_oe_out) && rise_reg == 4'h8; endsequence
	// Counts raw clock rises since start; the design sees them later
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rise_reg <= 4'h0;
			busy_reg <= 32'h0;
		end else begin
			if (scl_in && $fell(sda_in))
				rise_reg <= 4'h0;
			else if ($rose(scl_in) && rise_reg != 4'hF)
				rise_reg <= rise_reg + 4'h1;
			busy_reg <= write_busy_out ? busy_reg + 32'h1 : 32'h0;
		end
	end
	a_tap_one_hot: assert property ($onehot(tap_select_out))
		else $error("tap select not one-hot");
	a_tap_follows_wiper: assert property (
		tap_select_out == (64'h1 << $past(wiper_position_out)))
		else $error("tap select differs from wiper");
	a_sda_low_only: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("data changed while clock high");
	a_start_no_ack: assert property (start_seq |-> !sda_oe_out[*8])
		else $error("data driven right after start");
	a_ack_ninth: assert property ($rose(sda_oe_out) |-> rise_reg >= 4'h8)
		else $error("drive before eighth bit");
	a_ack_hold: assert property (
		ack_seq |-> sda_oe_out[*8] ##[1:30] !sda_oe_out)
		else $error("acknowledge length wrong");
	a_busy_no_ack: assert property (write_busy_out |-> !$rose(sda_oe_out))
		else $error("acknowledge while busy");
	a_busy_length: assert property (
		$fell(write_busy_out) |-> busy_reg == WRITE_CYCLES)
		else $error("write cycle length wrong");
	a_busy_frozen: assert property (
		write_busy_out && $past(write_busy_out) |-> $stable(wiper_position_out))
		else $error("wiper moved while busy");
endmodule // pot_slave_properties
`default_nettype wire

// *** pot_slave_tb_top.sv ***
// Self-checking bench of the potentiometer slave.
`timescale 1ns/100ps
`default_nettype none
module pot_slave_tb_top;
	localparam int         WC   = 400;
	localparam logic [7:0] ADDR = 8'hA9;
	logic        sys_clk_in, rst_n_in, prot_n, m_scl, m_sda, sda_oe;
	logic        busy, ack, ok;
	logic [63:0] tap;
	logic [5:0]  wip;
	logic [7:0]  rd;
	int          failures, n_tests;
	logic [23:0] rows [7] = '{24'hA03FFF, 24'hA000C0, 24'hA02AEA, 24'hD40040,
		24'hA015D5, 24'hA10015, 24'h300015};
	logic [7:0]  bad [5] = '{8'h59, 8'hA8, 8'hAB, 8'hA1, 8'hAD};
	logic [7:0]  rcmd [2] = '{8'h90, 8'hB8};
	logic        strap_lo, strap_mid, strap_hi, sda_pin;
	wire logic   sda_bus = m_sda & ~sda_oe;
	pot_slave #(.WRITE_CYCLES(WC)) dut (.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in), .scl_in(m_scl), .sda_in(sda_bus),
		.sda_out(sda_pin), .sda_oe_out(sda_oe),
		.addr_strap_bit_low_in(strap_lo),
		.addr_strap_bit_mid_in(strap_mid),
		.addr_strap_bit_high_in(strap_hi),
		.write_protect_n_in(prot_n), .tap_select_out(tap),
		.wiper_position_out(wip), .write_busy_out(busy));
	pot_bus_master m (.clk_in(sys_clk_in), .sda_in(sda_bus),
		.scl_out(m_scl), .sda_out(m_sda));
	task automatic check(input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] c, d, input logic hd, ca);
		m.start();
		m.send_byte(ADDR, ack);
		check(ack, 1'b1);
		m.send_byte(c, ack);
		check(ack, ca);
		if (hd) begin
			m.send_byte(d, ack);
			check(ack, 1'b1);
		end
		m.stop();
		m.wait_clk(8);
	endtask
	// Nonvolatile command, then poll until the address is answered again
	task automatic store(input logic [7:0] c, d, input logic hd);
		int k;
		xfer(c, d, hd, 1'b1);
		check(busy, prot_n);
		ack = 1'b0;
		for (k = 0; k < 20 && ack !== 1'b1; k++) begin
			m.start();
			m.send_byte(ADDR, ack);
			m.stop();
			if (k == 0 && prot_n) check(ack, 1'b0);
		end
		if (ack !== 1'b1) begin
			failures++;
			test_done();
		end
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		failures = 0;
		n_tests = 0;
		rst_n_in = 1'b0;
		prot_n = 1'b1;
		strap_lo = 1'b1;
		strap_mid = 1'b0;
		strap_hi = 1'b1;
		m.wait_clk(8);
		rst_n_in = 1'b1;
		m.wait_clk(8);
		foreach (rows[r]) begin
			xfer(rows[r][23:16], rows[r][15:8], rows[r][7], rows[r][6]);
			check(wip, rows[r][5:0]);
			check(tap, 64'h1 << rows[r][5:0]);
		end
		foreach (bad[b]) begin
			m.start();
			m.send_byte(bad[b], ack);
			check(ack, 1'b0);
			m.stop();
		end
		// Moved straps must move the answered address with them
		strap_lo = 1'b0;
		strap_mid = 1'b1;
		strap_hi = 1'b0;
		m.wait_clk(4);
		m.start();
		m.send_byte(8'hA4, ack);
		check(ack, 1'b1);
		m.stop();
		m.start();
		m.send_byte(ADDR, ack);
		check(ack, 1'b0);
		m.stop();
		strap_lo = 1'b1;
		strap_mid = 1'b0;
		strap_hi = 1'b1;
		m.wait_clk(4);
		store(8'hC8, 8'h2C, 1'b1);
		xfer(8'hD8, 8'h00, 1'b0, 1'b1);
		check(wip, 6'h2C);
		prot_n = 1'b0;
		store(8'hC8, 8'h11, 1'b1);
		prot_n = 1'b1;
		xfer(8'hD8, 8'h00, 1'b0, 1'b1);
		check(wip, 6'h2C);
		foreach (rcmd[j]) begin
			m.start();
			m.send_byte(ADDR, ack);
			m.send_byte(rcmd[j], ack);
			check(ack, 1'b1);
			m.read_byte(rd);
			m.stop();
			check(rd, 8'h2C);
		end
		xfer(8'hA0, 8'h01, 1'b1, 1'b1);
		m.start();
		m.send_byte(ADDR, ack);
		m.send_byte(8'h20, ack);
		m.send_bit(1'b1, ok);
		check(wip, 6'h02);
		repeat (3) m.send_bit(1'b0, ok);
		m.stop();
		check(wip, 6'h00);
		// Start in mid-command abandons it
		m.start();
		m.send_byte(ADDR, ack);
		repeat (2) m.send_bit(1'b1, ok);
		xfer(8'hA0, 8'h07, 1'b1, 1'b1);
		check(wip, 6'h07);
		// Saved wiper comes back through a store load
		store(8'hE4, 8'h00, 1'b0);
		xfer(8'hA0, 8'h00, 1'b1, 1'b1);
		xfer(8'hD4, 8'h00, 1'b0, 1'b1);
		check(wip, 6'h07);
		xfer(8'hC0, 8'h3F, 1'b1, 1'b1);
		rst_n_in = 1'b0;
		m.wait_clk(2);
		check(busy, 1'b0);
		check(tap, 64'h1);
		check(wip, 6'h00);
		check(sda_oe, 1'b0);
		check(sda_pin, 1'b0);
		rst_n_in = 1'b1;
		m.wait_clk(8);
		test_done();
	end
endmodule // pot_slave_tb_top
bind pot_slave pot_slave_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
	.sys_clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
	.addr_strap_bit_low_in, .addr_strap_bit_mid_in, .addr_strap_bit_high_in,
	.write_protect_n_in, .tap_select_out, .wiper_position_out,
	.write_busy_out);
`default_nettype wire
